// File: hdl/tes_pkg.sv
// Purpose: constants and types for the triggered exposure sequencer
// Assumes: core_clk at 250 MHz; times kept in microseconds, INT_MIN_CYC and DLY_MIN_CYC in cycles
// Notes:   registers are 32-bit words on an Avalon-MM slave
package tes_pkg;
    localparam int CLK_MHZ    = 250;
    localparam int US_CYC     = CLK_MHZ;  // cycles per microsecond
    localparam int INT_MIN_US = 6;
    localparam int INT_MAX_US = 225000;
    localparam int DLY_MIN_US = 12;
    localparam int DLY_MAX_US = 400000;
    localparam int TMO_US     = 2000000;
    localparam int INT_MIN_CYC = INT_MIN_US * US_CYC;
    localparam int DLY_MIN_CYC = DLY_MIN_US * US_CYC;
    localparam int TW = 21;  // wide enough for the timeout in us
    localparam int PW = 12;  // photodiode and pixel sample width
    typedef logic [TW-1:0] tes_us_t;
    typedef logic [PW-1:0] tes_smp_t;

    // register byte offsets
    localparam logic [4:0] REG_CTRL   = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_INT    = 5'h08;
    localparam logic [4:0] REG_DLY    = 5'h0c;
    localparam logic [4:0] REG_THR    = 5'h10;
    localparam logic [4:0] REG_PEAK   = 5'h14;
    // control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_TRIG  = 1;
    localparam int CTRL_EXT   = 2;
    localparam int CTRL_AUTO  = 3;
    // status bits
    localparam int ST_BUSY  = 0;
    localparam int ST_DONE  = 1;
    localparam int ST_TMO   = 2;
    localparam int ST_EXPO  = 3;
    localparam int ST_FOUND = 4;
    // reset values
    localparam tes_us_t  INT_RST = 21'h0003e8;  // 1 ms
    localparam tes_us_t  DLY_RST = 21'h00000c;  // 12 us
    localparam tes_smp_t THR_RST = 12'h800;
    localparam tes_smp_t SAT_RST = 12'hff0;

    typedef struct packed {
        logic auto_exp;
        logic src_ext;
        logic trig_en;
    } tes_cfg_t;

    typedef struct packed {
        logic gate;  // sensor integrating
        logic xfer;  // photo transfer, exposed frame only
        logic read;  // one-cycle readout request
    } tes_sens_t;

    typedef enum logic [2:0] {
        S_IDLE, S_WAIT, S_DLY, S_INT, S_READ
    } tes_state_t;
endpackage

// File: hdl/tes_seq.sv
// Purpose: exposure sequencer top with Avalon-MM register slave
// Assumes: sensor readout logic and ADC run on core_clk
// Notes:   INT and DLY writes are ignored while a measurement runs
`timescale 1ns/1ps
`default_nettype none
module tes_seq #(
    parameter int TICK_CYC   = tes_pkg::US_CYC,
    parameter int INT_MAX_US = tes_pkg::INT_MAX_US,
    parameter int DLY_MAX_US = tes_pkg::DLY_MAX_US,
    parameter int TIMEOUT_US = tes_pkg::TMO_US,
    parameter tes_pkg::tes_smp_t SAT_LEVEL = tes_pkg::SAT_RST
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic [4:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    output var  logic [31:0]        avs_readdata,
    output var  logic               avs_waitrequest,
    input  wire logic               ext_trig_pin,
    input  wire tes_pkg::tes_smp_t  pd_level,
    input  wire logic               sens_done,
    input  wire tes_pkg::tes_smp_t  sens_peak,
    output var  tes_pkg::tes_sens_t sens_o,
    output var  logic               busy
);
    localparam int TMW = tes_pkg::TW;
    // refuse settings that the timers and divider cannot hold
    if (TICK_CYC < 1 || TICK_CYC > 65535)
        $error("TICK_CYC out of range");
    if (INT_MAX_US < tes_pkg::INT_MIN_US || INT_MAX_US >= 2**(TMW-1))
        $error("INT_MAX_US out of range");
    if (DLY_MAX_US < tes_pkg::DLY_MIN_US || DLY_MAX_US >= 2**TMW)
        $error("DLY_MAX_US out of range");
    if (TIMEOUT_US < 1 || TIMEOUT_US >= 2**TMW)
        $error("TIMEOUT_US out of range");

    localparam tes_pkg::tes_us_t INT_MIN = TMW'(tes_pkg::INT_MIN_US);
    localparam tes_pkg::tes_us_t INT_MAX = TMW'(INT_MAX_US);
    localparam tes_pkg::tes_us_t DLY_MIN = TMW'(tes_pkg::DLY_MIN_US);
    localparam tes_pkg::tes_us_t DLY_MAX = TMW'(DLY_MAX_US);
    localparam tes_pkg::tes_us_t TMO_LIM = TMW'(TIMEOUT_US);
    // a shortened maximum must not leave the reset value above it
    localparam tes_pkg::tes_us_t INT_INIT = (tes_pkg::INT_RST > INT_MAX)
                                            ? INT_MAX : tes_pkg::INT_RST;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

    tes_pkg::tes_cfg_t   cfg_r;
    tes_pkg::tes_us_t    int_r;
    tes_pkg::tes_us_t    dly_r;
    tes_pkg::tes_smp_t   thr_r;
    tes_pkg::tes_smp_t   peak_r;
    tes_pkg::tes_state_t st_r;
    tes_pkg::tes_state_t st_nxt;
    tes_pkg::tes_us_t    tm_r;
    tes_pkg::tes_us_t    lim;
    logic [15:0]         div_r;
    logic [31:0]         rd_nxt;
    logic                expo_r;
    logic                expo_nxt;
    logic                done_r;
    logic                tmo_r;
    logic                found_r;
    logic                trig;
    logic                tick;
    logic                tm_hit;
    logic                acc;
    logic                wr_acc;
    logic                go;
    logic                rd_end;
    logic                auto_more;
    logic                auto_stop;
    logic                done_ev;
    logic                tmo_ev;
    logic                clr;
    tes_pkg::tes_us_t    int_dbl;
    tes_pkg::tes_us_t    int_back;

    tes_trig #(.PW(tes_pkg::PW)) u_trig (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .ext_trig_pin (ext_trig_pin),
        .src_ext      (cfg_r.src_ext),
        .pd_level     (pd_level),
        .thresh       (thr_r),
        .trig         (trig)
    );

    // one wait cycle per access; reads sample while waitrequest is
    // high, writes land only on the edge that completes the transfer
    assign acc    = (avs_read | avs_write) & avs_waitrequest;
    assign wr_acc = avs_write & ~avs_waitrequest;
    assign clr    = wr_acc && avs_address == tes_pkg::REG_STATUS;
    assign go     = wr_acc && avs_address == tes_pkg::REG_CTRL
                    && avs_writedata[tes_pkg::CTRL_START]
                    && st_r == tes_pkg::S_IDLE;

    // read mux, unmapped words read zero
    always_comb begin
        rd_nxt = 32'h0;
        unique case (avs_address)
            tes_pkg::REG_CTRL:   rd_nxt[3:1] = {cfg_r.auto_exp,
                                     cfg_r.src_ext, cfg_r.trig_en};
            tes_pkg::REG_STATUS: rd_nxt[4:0] = {found_r, expo_r, tmo_r,
                                     done_r, busy};
            tes_pkg::REG_INT:    rd_nxt[TMW-1:0] = int_r;
            tes_pkg::REG_DLY:    rd_nxt[TMW-1:0] = dly_r;
            tes_pkg::REG_THR:    rd_nxt[11:0] = thr_r;
            tes_pkg::REG_PEAK:   rd_nxt[11:0] = peak_r;
            default:             rd_nxt = 32'h0;
        endcase
    end

    // bus handshake
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
        end else if (acc) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_nxt;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    // auto exposure arithmetic, doubling clamps at the top
    assign rd_end    = st_r == tes_pkg::S_READ && sens_done;
    assign auto_more = cfg_r.auto_exp && sens_peak < SAT_LEVEL
                       && int_r < INT_MAX;
    assign auto_stop = rd_end && expo_r && cfg_r.auto_exp && !auto_more;
    assign done_ev   = rd_end && expo_r && !auto_more;
    assign int_dbl   = (int_r > (INT_MAX >> 1)) ? INT_MAX
                       : TMW'({int_r, 1'b0});
    assign int_back  = (int_r - (int_r >> 3) < INT_MIN) ? INT_MIN
                       : int_r - (int_r >> 3);

    // configuration; times clamp into the legal window
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= '0;
            int_r <= INT_INIT;
            dly_r <= tes_pkg::DLY_RST;
            thr_r <= tes_pkg::THR_RST;
        end else begin
            if (wr_acc && avs_address == tes_pkg::REG_CTRL && !busy) begin
                cfg_r.trig_en  <= avs_writedata[tes_pkg::CTRL_TRIG];
                cfg_r.src_ext  <= avs_writedata[tes_pkg::CTRL_EXT];
                cfg_r.auto_exp <= avs_writedata[tes_pkg::CTRL_AUTO];
            end
            if (wr_acc && avs_address == tes_pkg::REG_THR)
                thr_r <= avs_writedata[11:0];
            if (wr_acc && avs_address == tes_pkg::REG_DLY && !busy) begin
                if (avs_writedata < 32'(DLY_MIN))
                    dly_r <= DLY_MIN;
                else if (avs_writedata > 32'(DLY_MAX))
                    dly_r <= DLY_MAX;
                else
                    dly_r <= avs_writedata[TMW-1:0];
            end
            if (go && avs_writedata[tes_pkg::CTRL_AUTO]) begin
                int_r <= INT_MIN;
            end else if (rd_end && expo_r && cfg_r.auto_exp) begin
                int_r <= auto_more ? int_dbl : int_back;
            end else if (wr_acc && avs_address == tes_pkg::REG_INT
                         && !busy) begin
                if (avs_writedata < 32'(INT_MIN))
                    int_r <= INT_MIN;
                else if (avs_writedata > 32'(INT_MAX))
                    int_r <= INT_MAX;
                else
                    int_r <= avs_writedata[TMW-1:0];
            end
        end
    end

    // timer limit per state, counted in microsecond ticks
    always_comb begin
        unique case (st_r)
            tes_pkg::S_WAIT: lim = TMO_LIM;
            tes_pkg::S_DLY:  lim = dly_r;
            default:         lim = int_r;
        endcase
    end
    assign tick   = (div_r == TICK_LAST);
    assign tm_hit = tick && (tm_r == lim - 1'b1);
    assign tmo_ev = st_r == tes_pkg::S_WAIT && !trig && tm_hit;

    // sequence: dark frame, then exposed frame
    always_comb begin
        st_nxt   = st_r;
        expo_nxt = expo_r;
        unique case (st_r)
            tes_pkg::S_IDLE: if (go) begin
                expo_nxt = 1'b0;
                st_nxt = avs_writedata[tes_pkg::CTRL_TRIG]
                         ? tes_pkg::S_WAIT : tes_pkg::S_INT;
            end
            tes_pkg::S_WAIT: begin
                if (trig)
                    st_nxt = tes_pkg::S_DLY;
                else if (tm_hit)
                    st_nxt = tes_pkg::S_IDLE;
            end
            tes_pkg::S_DLY: if (tm_hit) begin
                st_nxt = tes_pkg::S_INT;
            end
            tes_pkg::S_INT: if (tm_hit) begin
                st_nxt = tes_pkg::S_READ;
            end
            tes_pkg::S_READ: if (sens_done) begin
                if (!expo_r || auto_more) begin
                    expo_nxt = ~expo_r;
                    st_nxt = cfg_r.trig_en ? tes_pkg::S_WAIT
                                           : tes_pkg::S_INT;
                end else begin
                    st_nxt = tes_pkg::S_IDLE;
                end
            end
        endcase
    end

    // state, divider and timer restart together on every change
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r   <= tes_pkg::S_IDLE;
            expo_r <= 1'b0;
            div_r  <= 16'h0;
            tm_r   <= '0;
        end else begin
            st_r   <= st_nxt;
            expo_r <= expo_nxt;
            if (st_nxt != st_r) begin
                div_r <= 16'h0;
                tm_r  <= '0;
            end else if (tick) begin
                div_r <= 16'h0;
                tm_r  <= tm_r + 1'b1;
            end else begin
                div_r <= div_r + 16'h1;
            end
        end
    end

    // sensor strobes; transfer only on the exposed frame
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sens_o <= '0;
            busy   <= 1'b0;
        end else begin
            sens_o.gate <= st_nxt == tes_pkg::S_INT;
            sens_o.xfer <= st_nxt == tes_pkg::S_INT && expo_nxt;
            sens_o.read <= st_nxt == tes_pkg::S_READ
                           && st_r != tes_pkg::S_READ;
            busy <= st_nxt != tes_pkg::S_IDLE;
        end
    end

    // sticky status: write one clears, a new event wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            done_r  <= 1'b0;
            tmo_r   <= 1'b0;
            found_r <= 1'b0;
            peak_r  <= '0;
        end else begin
            if (done_ev)
                done_r <= 1'b1;
            else if (clr && avs_writedata[tes_pkg::ST_DONE])
                done_r <= 1'b0;
            if (tmo_ev)
                tmo_r <= 1'b1;
            else if (clr && avs_writedata[tes_pkg::ST_TMO])
                tmo_r <= 1'b0;
            if (auto_stop)
                found_r <= 1'b1;
            else if (clr && avs_writedata[tes_pkg::ST_FOUND])
                found_r <= 1'b0;
            if (rd_end && expo_r)
                peak_r <= sens_peak;
        end
    end

    // cycles spent in the current state, for checking only
    logic [31:0] scnt_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            scnt_r <= 32'h1;
        else
            scnt_r <= (st_nxt != st_r) ? 32'h1 : scnt_r + 32'h1;
    end

    property p_int_len;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r == tes_pkg::S_INT && st_nxt != st_r)
            |-> scnt_r == 32'(int_r) * 32'(TICK_CYC);
    endproperty
    a_int_len: assert property (p_int_len)
        else $error("integration window length wrong");

    property p_int_rng;
        @(posedge core_clk) disable iff (!rst_n)
        int_r >= INT_MIN && int_r <= INT_MAX;
    endproperty
    a_int_rng: assert property (p_int_rng)
        else $error("integration time out of range");

    property p_gate_trig;
        @(posedge core_clk) disable iff (!rst_n)
        ($rose(sens_o.gate) && cfg_r.trig_en)
            |-> $past(st_r) == tes_pkg::S_DLY;
    endproperty
    a_gate_trig: assert property (p_gate_trig)
        else $error("gate opened without trigger and delay");

    property p_dly_len;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r == tes_pkg::S_DLY && st_nxt != st_r)
            |-> scnt_r == 32'(dly_r) * 32'(TICK_CYC);
    endproperty
    a_dly_len: assert property (p_dly_len)
        else $error("trigger delay length wrong");

    property p_dark_first;
        @(posedge core_clk) disable iff (!rst_n)
        (st_r == tes_pkg::S_IDLE && go) |=> !expo_r [*2];
    endproperty
    a_dark_first: assert property (p_dark_first)
        else $error("measurement did not start with dark frame");

    property p_dark_exp;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_end && !expo_r) |=> expo_r && st_r != tes_pkg::S_IDLE;
    endproperty
    a_dark_exp: assert property (p_dark_exp)
        else $error("dark frame not followed by exposed frame");

    property p_auto_up;
        @(posedge core_clk) disable iff (!rst_n)
        (rd_end && expo_r && auto_more)
            |=> int_r == (($past(int_r) > (INT_MAX >> 1)) ? INT_MAX
                          : TMW'({$past(int_r), 1'b0}));
    endproperty
    a_auto_up: assert property (p_auto_up)
        else $error("auto exposure step wrong");

    property p_auto_stop;
        @(posedge core_clk) disable iff (!rst_n)
        auto_stop |=> found_r && int_r <= $past(int_r)
                      && st_r == tes_pkg::S_IDLE;
    endproperty
    a_auto_stop: assert property (p_auto_stop)
        else $error("auto exposure did not settle below limit");

    property p_tmo;
        @(posedge core_clk) disable iff (!rst_n)
        tmo_ev |-> scnt_r == 32'(TMO_LIM) * 32'(TICK_CYC)
                   ##1 (tmo_r && !busy && st_r == tes_pkg::S_IDLE);
    endproperty
    a_tmo: assert property (p_tmo)
        else $error("trigger timeout wrong");

    property p_bus;
        @(posedge core_clk) disable iff (!rst_n)
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus request not answered in time");

    c_done: cover property (@(posedge core_clk) done_ev);
    c_tmo:  cover property (@(posedge core_clk) tmo_ev);
    c_auto: cover property (@(posedge core_clk) auto_stop);
    c_cw:   cover property (@(posedge core_clk)
                            done_ev && !cfg_r.trig_en);
endmodule
`default_nettype wire

// File: hdl/tes_trig.sv
// Purpose: trigger front end, source select and threshold crossing
// Assumes: pd_level comes from an ADC on core_clk; ext pin is async
// Notes:   one-cycle trig pulse, two cycles after the pin is sampled, same edge as a sampled crossing
`timescale 1ns/1ps
`default_nettype none
module tes_trig #(
    parameter int PW = tes_pkg::PW
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          ext_trig_pin,
    input  wire logic          src_ext,
    input  wire logic [PW-1:0] pd_level,
    input  wire logic [PW-1:0] thresh,
    output var  logic          trig
);
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic pd_over_r;
    logic pd_over;

    // two flops before anything looks at the pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_trig_pin;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    assign pd_over = (pd_level >= thresh);

    // rising crossing only, so a long pulse fires once
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pd_over_r <= 1'b0;
            trig      <= 1'b0;
        end else begin
            pd_over_r <= pd_over;
            trig <= src_ext ? (ext_s2_r & ~ext_s3_r)
                            : (pd_over & ~pd_over_r);
        end
    end

    property p_ext_edge;
        @(posedge core_clk) disable iff (!rst_n)
        ($past(src_ext) && trig) |-> (ext_s3_r && !$past(ext_s3_r));
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("external trigger without pin edge");

    property p_thr;
        @(posedge core_clk) disable iff (!rst_n)
        (!$past(src_ext) && trig) |-> (pd_over_r && !$past(pd_over_r));
    endproperty
    a_thr: assert property (p_thr)
        else $error("internal trigger without threshold crossing");

    c_ext: cover property (@(posedge core_clk) src_ext && trig);
endmodule
`default_nettype wire

// File: tb/tes_sensor_model.sv
// Purpose: image sensor stand-in that answers readout requests
// Assumes: peak grows 43 counts per gated cycle, dark or exposed, saturating
// Notes:   slow stretches readout latency; peak bus churns when idle
`timescale 1ns/1ps
`default_nettype none
module tes_sensor_model (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic               slow,
    input  wire tes_pkg::tes_sens_t sens_i,
    output var  logic               sens_done,
    output var  tes_pkg::tes_smp_t  sens_peak
);
    int w;
    int cnt;
    int pk;
    // count exposure, answer each read after a latency
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w = 0;
            cnt = 0;
            sens_done <= 1'b0;
            sens_peak <= 12'h000;
        end else begin
            sens_done <= 1'b0;
            sens_peak <= ~sens_peak;  // stale peak only on every other cycle between answers
            if (sens_i.gate) w = w + 1;
            if (sens_i.read) begin
                pk = (w * 43 > 4095) ? 4095 : w * 43;
                w = 0;
                cnt = slow ? 9 : 2;
            end else if (cnt > 0) begin
                cnt = cnt - 1;
                if (cnt == 0) begin
                    sens_done <= 1'b1;
                    sens_peak <= pk[11:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/triggered_exposure_sequencer_test.sv
// Purpose: self-checking bench for the exposure sequencer
// Assumes: 2 cycles per us, limits of 64 us and 50 us timeout
// Notes:   reads and windows are checked from queues by a monitor
`timescale 1ns/1ps
`default_nettype none
module triggered_exposure_sequencer_test;
    logic              core_clk;
    logic              rst_n;
    logic              avs_read;
    logic              avs_write;
    logic              ext_trig_pin;
    logic              sens_done;
    logic              busy;
    logic              avs_waitrequest;
    logic              slow;
    logic              gx;
    logic [4:0]        avs_address;
    logic [31:0]       avs_writedata;
    logic [31:0]       avs_readdata;
    tes_pkg::tes_smp_t pd_level;
    tes_pkg::tes_smp_t sens_peak;
    tes_pkg::tes_sens_t sens_o;
    int                mismatches;
    int                checks_done;
    int                cyc;
    int                gw;
    int                n;
    logic [31:0]       rq[$];
    logic [31:0]       gq[$];

    tes_seq #(.TICK_CYC(2), .INT_MAX_US(64), .DLY_MAX_US(64),
        .TIMEOUT_US(50)) i_tes_seq (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_trig_pin(ext_trig_pin),
        .pd_level(pd_level), .sens_done(sens_done),
        .sens_peak(sens_peak), .sens_o(sens_o), .busy(busy));
    tes_sensor_model i_tes_sensor_model (
        .core_clk(core_clk), .rst_n(rst_n), .slow(slow), .sens_i(sens_o),
        .sens_done(sens_done), .sens_peak(sens_peak));

    // 250 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] e);
        chk(got, e);
    endtask
    task automatic cmp_win(input logic [31:0] got, input logic [31:0] e);
        chk(got, e);
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a,
        input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) @(posedge core_clk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    // a measurement is a dark window then an exposed one
    task automatic win(input int us);
        gq.push_back(32'(2 * us));
        gq.push_back(32'h8000_0000 | 32'(2 * us));
    endtask
    task automatic idle;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge core_clk);
            n++;
        end
    endtask
    // quiet spell with the other source noisy, then one trigger
    task automatic fire(input logic ext, input int thr);
        int k;
        k = 0;
        // let the previous window close before the quiet spell
        while (sens_o.gate !== 1'b0) @(posedge core_clk);
        repeat (20) begin
            @(posedge core_clk);
            pd_level <= ext ? 12'($urandom) : 12'($urandom_range(thr - 1, 0));
            ext_trig_pin <= ext ? 1'b0 : 1'($urandom);
            if (sens_o.gate !== 1'b0) k = 99;
        end
        @(posedge core_clk);
        ext_trig_pin <= ext;
        pd_level <= ext ? 12'h000 : 12'(thr);
        while (sens_o.gate !== 1'b1 && k < 60) begin
            @(posedge core_clk);
            k++;
        end
        cmp_reg(32'(k >= 24 && k <= 31), 32'h1);
        ext_trig_pin <= 1'b0;
        pd_level <= 12'h000;
    endtask

    // monitor: read data and window lengths against the notes
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (avs_read && avs_waitrequest === 1'b0)
            cmp_reg(avs_readdata, rq.pop_front());
        if (sens_o.gate === 1'b1) begin
            gw++;
            gx = sens_o.xfer;
        end else if (gw > 0) begin
            cmp_win({gx, 31'(gw)}, gq.pop_front());
            gw = 0;
        end
        if (cyc > 20000) begin
            mismatches++;
            final_report;
        end
    end

    // main sequence
    initial begin
        {rst_n, avs_read, avs_write, ext_trig_pin, slow} = 5'h00;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        pd_level = 12'h000;
        {mismatches, checks_done, cyc, gw} = 0;
        void'($urandom(30));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(tes_pkg::REG_CTRL, 32'h0);
        rd(tes_pkg::REG_DLY, 32'hc);
        rd(tes_pkg::REG_THR, 32'h800);
        rd(tes_pkg::REG_PEAK, 32'h0);
        wr(5'h1c, 32'h5);
        rd(5'h1c, 32'h0);
        wr(tes_pkg::REG_INT, 32'h2);
        rd(tes_pkg::REG_INT, 32'h6);
        wr(tes_pkg::REG_INT, 32'h64);
        rd(tes_pkg::REG_INT, 32'h40);
        wr(tes_pkg::REG_DLY, 32'h3);
        rd(tes_pkg::REG_DLY, 32'hc);
        // free-running pair, INT write while busy must not land
        wr(tes_pkg::REG_INT, 32'ha);
        win(10);
        wr(tes_pkg::REG_CTRL, 32'h1);
        wr(tes_pkg::REG_INT, 32'h1e);
        idle;
        rd(tes_pkg::REG_INT, 32'ha);
        // exposed-frame bit stays up after the last frame
        rd(tes_pkg::REG_STATUS, 32'ha);
        rd(tes_pkg::REG_PEAK, 32'h35c);
        wr(tes_pkg::REG_STATUS, 32'h1f);
        rd(tes_pkg::REG_STATUS, 32'h8);
        // gated windows from the external pin, then the photodiode
        wr(tes_pkg::REG_INT, 32'h6);
        win(6);
        wr(tes_pkg::REG_CTRL, 32'h7);
        fire(1'b1, 1024);
        fire(1'b1, 1024);
        idle;
        wr(tes_pkg::REG_THR, 32'h400);
        win(6);
        wr(tes_pkg::REG_CTRL, 32'h3);
        fire(1'b0, 1024);
        fire(1'b0, 1024);
        idle;
        rd(tes_pkg::REG_STATUS, 32'ha);
        wr(tes_pkg::REG_STATUS, 32'h1f);
        // no trigger at all: abandon after 100 cycles
        wr(tes_pkg::REG_CTRL, 32'h3);
        idle;
        cmp_reg(32'(n >= 96 && n <= 104), 32'h1);
        rd(tes_pkg::REG_STATUS, 32'h4);
        wr(tes_pkg::REG_STATUS, 32'h1f);
        // exposure search saturates at 48 us, backs off to 42
        slow <= 1'b1;
        win(6);
        win(12);
        win(24);
        win(48);
        wr(tes_pkg::REG_CTRL, 32'h9);
        idle;
        rd(tes_pkg::REG_INT, 32'h2a);
        rd(tes_pkg::REG_STATUS, 32'h1a);
        rd(tes_pkg::REG_PEAK, 32'hfff);
        cmp_reg(32'(gq.size()), 32'h0);
        final_report;
    end
endmodule
`default_nettype wire
